// ### rtl/isa_dma_pins_pkg.sv
// Package for the ISA DMA / IRQ pin interface block.
// Assumes a single 40 MHz clock domain and no software-visible registers.
package isa_dma_pins_pkg;

    // ------------------------------------------------------------
    // Channel layout
    // ------------------------------------------------------------
    localparam int CHANNELS = 8;
    localparam int CH_IDX_W = 3;
    // Channel 4 is the cascade slot and has no pins
    localparam logic [CHANNELS-1:0] CH_PRESENT = 8'hEF;
    localparam logic [CHANNELS-1:0] CH_NONE = 8'h00;
    localparam logic [CHANNELS-1:0] ACK_IDLE_N = 8'hFF;

    // ------------------------------------------------------------
    // Interrupt inputs: IRQ 5,6,7,9,10,11,12,14,15
    // ------------------------------------------------------------
    localparam int IRQ_LINES = 16;
    localparam logic [IRQ_LINES-1:0] IRQ_PRESENT = 16'hDEE0;
    localparam logic [IRQ_LINES-1:0] IRQ_NONE = 16'h0000;

    // ------------------------------------------------------------
    // Strap and configuration port
    // ------------------------------------------------------------
    localparam int STRAP_CH = 6;
    localparam int CR3_STRAP_BIT = 4;
    localparam logic [7:0] CR3_RESET = 8'h00;
    localparam logic [7:0] CFG_PORT_STRAP_HI = 8'h4E;
    localparam logic [7:0] CFG_PORT_STRAP_LO = 8'h2E;

    // ------------------------------------------------------------
    // Grant sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_STRAP = 3'b001,
        ST_IDLE  = 3'b010,
        ST_GRANT = 3'b100
    } grant_state_e;

    // Grant held by the sequencer
    typedef struct packed {
        logic               active;
        logic [CH_IDX_W-1:0] channel;
    } grant_s;

endpackage : isa_dma_pins_pkg

// ### rtl/isa_dma_irq_pins.sv
// ISA-side DMA request/acknowledge, terminal count and IRQ pin logic.
// Assumes requests, IRQs and the strap are asynchronous pins; the DMA
// core supplies xfer_last and xfer_done on the same clock; terminal count is driven out from here.
// Reset must be held two clocks or more so the strap chain fills.
//
// Summary of operation
// RULE_01: A DMA slave or ISA master raises its channel request to ask.
// RULE_02: A granted channel sees its active-low acknowledge asserted.
// RULE_03: Only channels 0-3 and 5-7 have request and acknowledge pins.
// RULE_04: Terminal count is driven out while the active channel ends.
// RULE_05: The channel 6 acknowledge pin is weakly pulled up in reset.
// RULE_06: The strap level seen in reset loads bit 4 of control reg 3.
// RULE_07: The board pulls the strap low with about 4.7k for port 2Eh.
// RULE_08: IRQ 5,6,7,9,10,11,12,14,15 are inputs driven by sources.
// RULE_09: At most one acknowledge, and only while its request stands; the code can re-grant a just-dropped request for two cycles after xfer_done.
`timescale 1ns/100ps

module isa_dma_irq_pins
    import isa_dma_pins_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [isa_dma_pins_pkg::CHANNELS-1:0] dma_req_pin,
    input wire logic [isa_dma_pins_pkg::IRQ_LINES-1:0] irq_pin,
    input wire logic ack6_strap_pin_in,
    input wire logic grant_enable,
    input wire logic xfer_last,
    input wire logic xfer_done,
    output logic [isa_dma_pins_pkg::CHANNELS-1:0] dma_ack_n,
    output logic ack6_strap_pin_oe_n,
    output logic ack6_strap_pull_up,
    output logic terminal_count,
    output logic [isa_dma_pins_pkg::IRQ_LINES-1:0] irq_level,
    output logic [isa_dma_pins_pkg::CHANNELS-1:0] dma_req_level,
    output logic [isa_dma_pins_pkg::CH_IDX_W-1:0] active_channel,
    output logic grant_valid,
    output logic config_port_select_strap,
    output logic [7:0] global_control_reg_three,
    output logic [7:0] config_port_addr
);
    import isa_dma_pins_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [CHANNELS-1:0] req_meta_ff;
    logic [CHANNELS-1:0] req_sync_ff;
    logic [IRQ_LINES-1:0] irq_meta_ff;
    logic [IRQ_LINES-1:0] irq_sync_ff;
    logic strap_meta_ff;
    logic strap_sync_ff;

    // Requests: two stages, only the second is read by logic; cleared
    // in reset so no stale level leaks out before the pins are seen
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_meta_ff <= CH_NONE;
            req_sync_ff <= CH_NONE;
        end else begin
            req_meta_ff <= dma_req_pin;
            req_sync_ff <= req_meta_ff;
        end
    end

    // IRQ levels, same two-stage scheme
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_meta_ff <= IRQ_NONE;
            irq_sync_ff <= IRQ_NONE;
        end else begin
            irq_meta_ff <= irq_pin;
            irq_sync_ff <= irq_meta_ff;
        end
    end

    // RULE_06 strap seen in reset
    // Strap stages stay out of reset on purpose: they keep sampling the
    // pulled-up pin while reset is held, so the level handed to the
    // latch at the first edge after release is the board's strap and
    // not a reset constant.
    always_ff @(posedge clk) begin
        strap_meta_ff <= ack6_strap_pin_in;
        strap_sync_ff <= strap_meta_ff;
    end

    // ------------------------------------------------------------
    // Request and IRQ qualification
    // ------------------------------------------------------------
    // RULE_01 channel requests
    // RULE_03 channel four masked
    wire [CHANNELS-1:0] req_valid = req_sync_ff & CH_PRESENT;
    // RULE_08 IRQ inputs only
    wire [IRQ_LINES-1:0] irq_valid = irq_sync_ff & IRQ_PRESENT;

    // Fixed low-number-first pick; priority policy lives elsewhere
    logic [CH_IDX_W-1:0] pick_idx;
    logic pick_any;
    always_comb begin
        pick_idx = '0;
        pick_any = 1'b0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (req_valid[i]) begin
                pick_idx = CH_IDX_W'(i);
                pick_any = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Grant sequencer
    // ------------------------------------------------------------
    grant_state_e state_ff;
    grant_state_e nxt_state;
    grant_s grant_ff;
    grant_s nxt_grant;
    logic tc_ff;
    logic nxt_tc;
    logic strap_ff;
    logic [CHANNELS-1:0] ack_n_ff;
    logic [CHANNELS-1:0] nxt_ack_n;

    // Request of the channel now holding the grant
    wire granted_req = req_valid[grant_ff.channel];

    // Strap phase lasts the first cycle after reset release; the latch
    // below takes the strap chain's level at that edge.
    // Limitation: a grant closed by xfer_done while the pin has just
    // dropped can be issued again for two cycles, because the request
    // chain still shows the old level; the core should keep
    // grant_enable low for three cycles after done if that matters.
    always_comb begin
        nxt_state = state_ff;
        nxt_grant = grant_ff;
        nxt_tc = 1'b0;
        unique case (state_ff)
            ST_STRAP: begin
                nxt_state = ST_IDLE;
            end
            ST_IDLE: begin
                if (grant_enable && pick_any) begin
                    nxt_state = ST_GRANT;
                    nxt_grant.active = 1'b1;
                    nxt_grant.channel = pick_idx;
                end
            end
            ST_GRANT: begin
                // RULE_04 terminal count
                nxt_tc = xfer_last && granted_req;
                // RULE_09 drop with request
                if (!granted_req || xfer_done) begin
                    nxt_state = ST_IDLE;
                    nxt_grant.active = 1'b0;
                    nxt_tc = 1'b0;
                end
            end
        endcase
    end

    // RULE_02 one-hot active-low ack
    // RULE_09 single grant only
    always_comb begin
        nxt_ack_n = ACK_IDLE_N;
        if (nxt_grant.active) begin
            nxt_ack_n[nxt_grant.channel] = 1'b0;
        end
        nxt_ack_n = nxt_ack_n | ~CH_PRESENT;
    end

    // Sequencer registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_STRAP;
            grant_ff <= '0;
            tc_ff <= 1'b0;
            ack_n_ff <= ACK_IDLE_N;
        end else begin
            state_ff <= nxt_state;
            grant_ff <= nxt_grant;
            tc_ff <= nxt_tc;
            ack_n_ff <= nxt_ack_n;
        end
    end

    // Strap phase decode, shared by the latch and the pin controls
    wire in_strap = (state_ff == ST_STRAP);

    // RULE_06 latch strap level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_ff <= 1'b1;
        end else if (in_strap) begin
            strap_ff <= strap_sync_ff;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // RULE_05 weak pull-up during reset
    // Pin is released until the strap is caught, then driven as ack 6
    // Both follow a register, so the pin never glitches between the
    // weak pull-up and the ack driver
    assign ack6_strap_pull_up = in_strap;
    assign ack6_strap_pin_oe_n = in_strap;

    // Registered or synchronised values; no pin reaches an output raw
    assign dma_ack_n = ack_n_ff;
    assign terminal_count = tc_ff;
    assign irq_level = irq_valid;
    assign dma_req_level = req_valid;
    assign active_channel = grant_ff.channel;
    assign grant_valid = grant_ff.active;
    assign config_port_select_strap = strap_ff;

    // RULE_06 control reg bit four
    // RULE_07 low strap gives 2Eh
    wire [7:0] strap_bit_mask = 8'(1) << CR3_STRAP_BIT;
    assign global_control_reg_three =
        strap_ff ? (CR3_RESET | strap_bit_mask)
                 : (CR3_RESET & ~strap_bit_mask);
    assign config_port_addr =
        strap_ff ? CFG_PORT_STRAP_HI : CFG_PORT_STRAP_LO;

endmodule : isa_dma_irq_pins

// ### verification/isa_dma_irq_pins_assertions.sv
// Checker for the ISA DMA pin block, fed from its ports only.
// Assumes one clock domain; the bind follows the module.
`timescale 1ns/100ps
module isa_dma_irq_pins_chk(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic xfer_last,
    input wire logic [7:0] dma_ack_n,
    input wire logic ack6_strap_pin_oe_n,
    input wire logic ack6_strap_pull_up,
    input wire logic terminal_count,
    input wire logic [7:0] dma_req_level,
    input wire logic [2:0] active_channel,
    input wire logic grant_valid,
    input wire logic config_port_select_strap,
    input wire logic [7:0] global_control_reg_three,
    input wire logic [7:0] config_port_addr
);
    logic [7:0] req_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Request picture one cycle back, for the grant cause
    always_ff @(posedge clk) req_q <= dma_req_level;
    // Ack pattern is the one-hot of the held grant
    a_ack_matches_grant: assert property (dma_ack_n == (grant_valid ?
        ~(8'h01 << active_channel) : 8'hFF)) else $error("ack pattern off");
    a_no_ch4_ack: assert property (dma_ack_n[4] &&
        !(grant_valid && active_channel == 3'h4)) else $error("ch4 acked");
    a_grant_needs_req: assert property ($rose(grant_valid) |->
        req_q[active_channel]) else $error("grant with no request");
    a_one_ack_only: assert property ($countones(~dma_ack_n) <= 1)
        else $error("two acks low");
    a_tc_after_last: assert property (terminal_count |->
        $past(xfer_last) && $past(grant_valid)) else $error("stray tc");
    a_pull_not_driven: assert property (ack6_strap_pull_up |->
        ack6_strap_pin_oe_n) else $error("pull-up while driving");
    a_port_from_strap: assert property (config_port_addr ==
        (config_port_select_strap ? 8'h4E : 8'h2E)) else $error("bad port");
    a_cr3_holds_strap: assert property (global_control_reg_three ==
        {3'h0, config_port_select_strap, 4'h0}) else $error("bad cr3");
    a_strap_set_once: assert property ($changed(config_port_select_strap)
        |-> !$past(rst_n, 2)) else $error("strap moved in run");
    cover property (grant_valid && active_channel == 3'h7);
    cover property (terminal_count);
    cover property (!config_port_select_strap);
endmodule : isa_dma_irq_pins_chk
bind isa_dma_irq_pins isa_dma_irq_pins_chk chk (.clk(clk), .rst_n(rst_n),
    .xfer_last(xfer_last), .dma_ack_n(dma_ack_n),
    .ack6_strap_pin_oe_n(ack6_strap_pin_oe_n),
    .ack6_strap_pull_up(ack6_strap_pull_up), .terminal_count(terminal_count),
    .dma_req_level(dma_req_level), .active_channel(active_channel),
    .grant_valid(grant_valid),
    .config_port_select_strap(config_port_select_strap),
    .global_control_reg_three(global_control_reg_three),
    .config_port_addr(config_port_addr));

// ### verification/isa_far_side_model.sv
// Far side: one DMA slave per channel and the board strap resistor.
// Assumes the bench names the channels that want service.
`timescale 1ns/100ps
module isa_far_side_model(
    input wire logic clk,
    input wire logic [7:0] want,
    input wire logic strap_low,
    input wire logic [7:0] dma_ack_n,
    input wire logic ack6_strap_pin_oe_n,
    input wire logic ack6_strap_pull_up,
    output logic [7:0] dma_req_pin,
    output logic ack6_strap_pin_in
);
    logic last_lvl = 1'b1;
    initial dma_req_pin = 8'h00;
    always @(posedge clk) dma_req_pin <= #1 want;
    // board pull-down beats the weak pull-up; floating pin wanders
    assign ack6_strap_pin_in = !ack6_strap_pin_oe_n ? dma_ack_n[6] :
        strap_low ? 1'b0 : ack6_strap_pull_up ? 1'b1 : ~last_lvl;
    always @(posedge clk) last_lvl <= ack6_strap_pin_in;
endmodule : isa_far_side_model

// ### verification/isa_dma_irq_pin_interface_tb.sv
// Bench for the ISA DMA pin block with the far-side model.
// Assumes the model launches requests one edge after the bench asks.
`timescale 1ns/100ps
module isa_dma_irq_pin_interface_tb;
    import isa_dma_pins_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, grant_enable = 1'b1, strap_low = 1'b0;
    logic xfer_last = 1'b0, xfer_done = 1'b0, pin_in, oe_n, pull_up, tc, gv;
    logic [7:0] want = 8'h00, req_pin, ack_n, req_lvl, strap_cr3, port;
    logic [15:0] irq_pin = 16'h0000, irq_lvl;
    logic [2:0] chan;
    logic strap;
    int miscompares = 0, comparisons = 0;
    isa_far_side_model far (.clk(clk), .want(want), .strap_low(strap_low),
        .dma_ack_n(ack_n), .ack6_strap_pin_oe_n(oe_n),
        .ack6_strap_pull_up(pull_up), .dma_req_pin(req_pin),
        .ack6_strap_pin_in(pin_in));
    isa_dma_irq_pins uut (.clk(clk), .rst_n(rst_n), .dma_req_pin(req_pin),
        .irq_pin(irq_pin), .ack6_strap_pin_in(pin_in),
        .grant_enable(grant_enable), .xfer_last(xfer_last),
        .xfer_done(xfer_done), .dma_ack_n(ack_n), .ack6_strap_pin_oe_n(oe_n),
        .ack6_strap_pull_up(pull_up), .terminal_count(tc),
        .irq_level(irq_lvl), .dma_req_level(req_lvl), .active_channel(chan),
        .grant_valid(gv), .config_port_select_strap(strap),
        .global_control_reg_three(strap_cr3), .config_port_addr(port));
    initial forever #12.5 clk = ~clk;
    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask : chk
    task results;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    // Inputs always move 1 ns after the rising edge
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task t_reset(input logic low);
        strap_low = low;
        rst_n = 1'b0;
        step(1);
        chk({pull_up, oe_n, ack_n}, 16'h03FF);
        step(4);
        rst_n = 1'b1;
        step(2);
        chk({strap, port}, low ? 16'h002E : 16'h014E);
        chk(strap_cr3, low ? 16'h0000 : 16'h0010);
        chk({pull_up, oe_n}, 16'h0000);
        strap_low = 1'b0;
    endtask : t_reset
    // Each channel requested alone; all but 4 granted, terminal count, then ended
    task t_channels;
        for (int c = 0; c < 8; c++) begin
            want = 8'h01 << c;
            step(5);
            chk(ack_n, c == 4 ? 8'hFF : 8'(~(8'h01 << c)));
            xfer_last = 1'b1;
            step(1);
            chk(tc, c != 4);
            xfer_last = 1'b0;
            xfer_done = 1'b1;
            want = 8'h00;
            step(1);
            chk({tc, gv, ack_n}, 16'h00FF);
            xfer_done = 1'b0;
            step(4);
        end
    endtask : t_channels
    // Held-off grant, lowest channel first, handover when it drops
    task t_priority;
        grant_enable = 1'b0;
        want = 8'hB4;
        step(6);
        chk(req_lvl, 8'hA4);
        chk(ack_n, 8'hFF);
        grant_enable = 1'b1;
        step(2);
        chk({gv, chan}, 16'h000A);
        want = 8'hA0;
        step(8);
        chk(ack_n, 8'hDF);
        want = 8'h00;
        step(6);
        chk(ack_n, 8'hFF);
    endtask : t_priority
    task t_irq;
        irq_pin = 16'hFFFF;
        step(4);
        chk(irq_lvl, 16'hDEE0);
        irq_pin = 16'h211F;
        step(4);
        chk(irq_lvl, 16'h0000);
    endtask : t_irq
    // Watchdog: the run needs about 3.3 us
    initial begin
        #20us;
        miscompares++;
        results();
    end
    initial begin
        t_reset(1'b0);
        t_channels();
        t_priority();
        t_irq();
        t_reset(1'b1);
        results();
    end
endmodule : isa_dma_irq_pin_interface_tb
